//--- pmsup_mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmsup_mcu_model (
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // Bench commands
  input wire logic         want_can_flash,
  input wire logic         want_lin_flash,
  // Device side
  input wire logic         lin_rx_wake_irq_pin_n,
  output logic             lin_tx_flash,
  output logic             can_tx_flash,
  output logic [31:0]      irq_count,
  output logic [31:0]      irq_len
);
  logic [31:0] run_reg;
  // Flash levels and wake pulse measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_tx_flash <= 1'b0;
      can_tx_flash <= 1'b0;
      irq_count    <= 32'h0000_0000;
      irq_len      <= 32'h0000_0000;
      run_reg      <= 32'h0000_0000;
    end else begin
      // never both pins at flash level
      lin_tx_flash <= want_can_flash && !can_tx_flash;
      can_tx_flash <= want_lin_flash && !want_can_flash && !lin_tx_flash;
      if (!lin_rx_wake_irq_pin_n) begin
        run_reg <= run_reg + 32'h0000_0001;
      end else if (run_reg != 32'h0000_0000) begin
        irq_len   <= run_reg;
        irq_count <= irq_count + 32'h0000_0001;
        run_reg   <= 32'h0000_0000;
      end
    end
  end
endmodule : pmsup_mcu_model
`default_nettype wire

//--- pmsup_pkg.sv
package pmsup_pkg;
  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned THERM_OFF_MS    = 1000;   // Thermal off time, ms
  localparam int unsigned THERM_WIN_MS    = 60000;  // Restart observation window, ms
  localparam int unsigned FAIL_FILT_NS    = 2000;   // Supply fail filter, ns
  localparam int unsigned SHORT_DET_US    = 4000;   // Short detection time, us
  localparam int unsigned WAKE_PULSE_US   = 56;     // Wake indication pulse, us
  localparam int unsigned THERM_OFF_CYC   = CLK_HZ / 1000 * THERM_OFF_MS;
  localparam int unsigned THERM_WIN_CYC   = CLK_HZ / 1000 * THERM_WIN_MS;
  localparam int unsigned FAIL_FILT_CYC   = (FAIL_FILT_NS * 25 + 999) / 1000;
  localparam int unsigned SHORT_DET_CYC   = CLK_HZ / 1000 / 1000 * SHORT_DET_US;
  localparam int unsigned WAKE_PULSE_CYC  = CLK_HZ / 1000 / 1000 * WAKE_PULSE_US;
  localparam logic [2:0]  RESTART_LIMIT   = 3'h7;
  localparam int unsigned CNT_W           = 32;

  // ------------------------------------------------------------------
  // APB register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAKE   = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADDR_WDOG   = 8'h10;

  // Control fields
  localparam int CTRL_STBY_CMD  = 0;   // Write 1: enter regulated standby
  localparam int CTRL_DEEP_CMD  = 1;   // Write 1: enter deep standby
  localparam int CTRL_AUX_ON    = 2;   // Aux regulator enable
  localparam int CTRL_HS_ON     = 3;   // High-side outputs enable
  localparam int CTRL_REL_ON    = 4;   // Relay outputs enable
  // Wake enable fields: can, lin, wake inputs 2..4, timer 5
  localparam logic [5:0] WAKE_EN_RESET = 6'h1F;
  localparam logic [4:0] CTRL_RESET    = 5'h1C;
  // Status clear fields
  localparam int CLR_MAIN_FAIL  = 0;
  localparam int CLR_AUX_FAIL   = 1;
  localparam int CLR_AUX_SHORT  = 2;
  localparam int CLR_FORCED     = 3;

  typedef enum logic [2:0] {
    PMSUP_ACTIVE, PMSUP_FLASH_CAN, PMSUP_FLASH_LIN,
    PMSUP_REG_STBY, PMSUP_THERM_OFF, PMSUP_DEEP_STBY
  } pmsup_mode_e;
endpackage : pmsup_pkg

//--- pmsup_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pmsup_properties
  import pmsup_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus request
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Monitors
  input wire logic        thermal_level_one,
  input wire logic        thermal_level_two,
  input wire logic        lin_tx_flash,
  input wire logic        can_tx_flash,
  // Controls
  input wire logic        main_regulator_en,
  input wire logic        aux_regulator_en,
  input wire logic        main_low_current,
  input wire logic        hs_out_en,
  input wire logic        relay_en,
  input wire logic        lin_tx_en,
  input wire logic        watchdog_run,
  input wire logic        watchdog_long_window,
  input wire logic        lin_rx_wake_irq_pin_n,
  input wire logic        mcu_reset_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic [31:0] low_cnt_reg;
  logic [31:0] low_cnt_next;
  logic        stby_wr;
  // Standby command landing on the bus
  assign stby_wr = psel && penable && pwrite && paddr == ADDR_CTRL && pwdata[CTRL_STBY_CMD];
  // Length of the current low phase, reset by any high sample
  assign low_cnt_next = lin_rx_wake_irq_pin_n ? 32'h0000_0000 : low_cnt_reg + 32'h0000_0001;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_reg <= 32'h0000_0000;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  // Two-cycle look so a flash exit in the same cycle is not counted
  sequence stby_cmd_s;
    !(lin_tx_flash || can_tx_flash) ##1
    (!(lin_tx_flash || can_tx_flash) && main_regulator_en && stby_wr);
  endsequence
  sequence flash_cmd_s;
    lin_tx_flash ##1 (lin_tx_flash && stby_wr);
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_level_one_off: assert property (
    thermal_level_one ##1 thermal_level_one |-> !(hs_out_en || relay_en || aux_regulator_en || lin_tx_en))
    else $error("outputs on during thermal level one");
  a_level_two_off: assert property (
    $rose(thermal_level_two) ##1 thermal_level_two |-> !main_regulator_en)
    else $error("main regulator on after thermal level two");
  a_main_off_hold: assert property (
    $fell(main_regulator_en) |-> !main_regulator_en [*8])
    else $error("main regulator back on too early");
  a_flash_no_wdog: assert property (
    (lin_tx_flash || can_tx_flash) ##1 (lin_tx_flash || can_tx_flash) |-> !watchdog_run)
    else $error("watchdog running in flash mode");
  a_flash_refuse_stby: assert property (
    flash_cmd_s |=> $stable(relay_en) && $stable(lin_tx_en))
    else $error("standby accepted from flash mode");
  a_exit_no_reset: assert property (
    $fell(lin_tx_flash) |-> mcu_reset_out_n [*4])
    else $error("reset pulse at flash exit");
  a_exit_long_window: assert property (
    $fell(can_tx_flash) |-> ##[1:3] watchdog_long_window)
    else $error("no long window after flash exit");
  a_low_current_wdog: assert property (
    main_low_current |-> !watchdog_run)
    else $error("watchdog running in low current mode");
  a_stby_outputs_off: assert property (
    stby_cmd_s |=> !(relay_en || lin_tx_en))
    else $error("relay or lin transmitter on in standby");
  a_wake_pulse_len: assert property (
    $rose(lin_rx_wake_irq_pin_n) |-> low_cnt_reg == WAKE_PULSE_CYC)
    else $error("wake pulse length wrong");
endmodule : pmsup_properties
bind pmsup_top pmsup_properties u_props (.*);
`default_nettype wire

//--- pmsup_top.sv
// Function
// - Thermal level one turns off high-side, relay, aux regulator and LIN output.
// - Thermal level two also turns main regulator off for one second.
// - During the thermal off time all other wake sources are ignored.
// - Retry after off time; seven failed restarts in a minute force deep standby.
// - Main regulator short after turn-on forces deep standby.
// - Forced deep standby wakes on CAN, LIN, wake inputs or wake timer.
// - Each regulator latches a fail flag after 2 us low, cleared by command.
// - Regulator still low 4 ms after turn-on is a short; switch it off.
// - Main short sets forced deep standby flag and main supply fail flag.
// - Aux short sets aux short flag and aux supply fail flag.
// - Once a regulator rose above threshold its short detection is disabled.
// - Flash voltage on lin tx enters CAN flash, on can tx LIN flash.
// - CAN flash enables CAN transmitter and receiver and stops the watchdog; rest as active.
// - No transition from a flash mode into either standby, except deep standby on a main short.
// - Leaving flash gives no reset pulse; watchdog starts with long window.
// - Watchdog enable bit clears only in CAN flash; stays off afterwards.
// - Regulated standby only by command; low current mode disables watchdog.
// - Regulated standby turns off relays and LIN/CAN transmitters; keeps others.
// - Enabled wake in regulated standby returns to active and pulses irq pin.
// - After reset all wake sources enabled except the wake interrupt timer.
// - Timer expiry in regulated standby pulses irq pin and enters active.
// - Each wake indication, except load current, is one 56 us low pulse.
`timescale 1ns/10ps
`default_nettype none
module pmsup_top
  import pmsup_pkg::*;
#(
  parameter int unsigned THERM_OFF_CYCLES = THERM_OFF_CYC,
  parameter int unsigned THERM_WIN_CYCLES = THERM_WIN_CYC,
  parameter int unsigned SHORT_DET_CYCLES = SHORT_DET_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Analogue monitors
  input  wire logic        thermal_level_one,
  input  wire logic        thermal_level_two,
  input  wire logic        main_regulator_low,
  input  wire logic        aux_regulator_low,
  input  wire logic        load_current_low,
  input  wire logic        lin_tx_flash,
  input  wire logic        can_tx_flash,
  // Wake sources
  input  wire logic        can_wake,
  input  wire logic        lin_wake,
  input  wire logic [2:0]  wake_inputs,
  input  wire logic        wake_interrupt_timer,
  // Controls
  output logic             main_regulator_en,
  output logic             aux_regulator_en,
  output logic             main_low_current,
  output logic             hs_out_en,
  output logic             relay_en,
  output logic             lin_tx_en,
  output logic             can_trx_en,
  output logic             watchdog_run,
  output logic             watchdog_long_window,
  output logic             lin_rx_wake_irq_pin_n,
  output logic             mcu_reset_out_n
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  pmsup_mode_e      mode_reg, mode_next;
  logic [4:0]       ctrl_reg;
  logic [5:0]       wake_en_reg;
  logic             watchdog_enable_bit_reg;
  logic             main_fail_reg, aux_fail_reg, aux_short_reg, forced_reg;
  logic             main_up_reg, aux_up_reg;
  logic [CNT_W-1:0] main_low_cnt_reg, aux_low_cnt_reg;
  logic [CNT_W-1:0] main_on_cnt_reg, aux_on_cnt_reg;
  logic [CNT_W-1:0] toff_cnt_reg, win_cnt_reg, pulse_cnt_reg;
  logic [2:0]       restart_cnt_reg;
  logic             aux_short_off_reg, low_cur_reg, long_win_reg;
  logic [2:0]       wake_in_d_reg;
  logic             tx_flash_d_reg;

  // Saturating counter step used by every timer except the down-counting wake pulse counter
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction : sat_inc

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire wr_en   = psel & penable & pwrite;
  wire wr_ctrl = wr_en & (paddr == ADDR_CTRL);
  wire wr_wake = wr_en & (paddr == ADDR_WAKE);
  wire wr_clr  = wr_en & (paddr == ADDR_CLR);
  wire wr_wdog = wr_en & (paddr == ADDR_WDOG);
  wire mapped  = (paddr == ADDR_CTRL) | (paddr == ADDR_WAKE) | (paddr == ADDR_STAT)
               | (paddr == ADDR_CLR) | (paddr == ADDR_WDOG);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ------------------------------------------------------------------
  // Supply monitors and wake decode
  // ------------------------------------------------------------------
  // filtered fail detect
  wire main_fail_evt = main_low_cnt_reg >= CNT_W'(FAIL_FILT_CYC);
  wire aux_fail_evt  = aux_low_cnt_reg >= CNT_W'(FAIL_FILT_CYC);
  wire main_short = main_regulator_en & ~main_up_reg & main_regulator_low
                  & (main_on_cnt_reg >= CNT_W'(SHORT_DET_CYCLES));
  wire aux_short  = aux_regulator_en & ~aux_up_reg & aux_regulator_low
                  & (aux_on_cnt_reg >= CNT_W'(SHORT_DET_CYCLES));
  wire [2:0] wake_edge = wake_inputs ^ wake_in_d_reg;
  wire wake_hw  = (can_wake & wake_en_reg[0]) | (lin_wake & wake_en_reg[1])
                | (|(wake_edge & wake_en_reg[4:2]));
  wire wake_tmr = wake_interrupt_timer & wake_en_reg[5];
  wire in_flash = (mode_reg == PMSUP_FLASH_CAN) | (mode_reg == PMSUP_FLASH_LIN);
  wire toff_done = toff_cnt_reg >= CNT_W'(THERM_OFF_CYCLES);
  wire win_done  = win_cnt_reg >= CNT_W'(THERM_WIN_CYCLES);
  wire tx_flash  = lin_tx_flash | can_tx_flash;

  // ------------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      PMSUP_ACTIVE: begin
        if (lin_tx_flash) begin
          mode_next = PMSUP_FLASH_CAN;
        end else if (can_tx_flash) begin
          mode_next = PMSUP_FLASH_LIN;
        end else if (wr_ctrl & pwdata[CTRL_STBY_CMD]) begin
          mode_next = PMSUP_REG_STBY;
        end else if (wr_ctrl & pwdata[CTRL_DEEP_CMD]) begin
          mode_next = PMSUP_DEEP_STBY;
        end
      end
      // flash modes leave to active; only thermal level two or a main short overrides
      PMSUP_FLASH_CAN, PMSUP_FLASH_LIN: begin
        if (!tx_flash) begin
          mode_next = PMSUP_ACTIVE;
        end
      end
      PMSUP_REG_STBY: begin
        if (wake_hw | wake_tmr) begin
          mode_next = PMSUP_ACTIVE;
        end
      end
      PMSUP_THERM_OFF: begin
        if (toff_done) begin
          mode_next = (restart_cnt_reg >= RESTART_LIMIT) ? PMSUP_DEEP_STBY : PMSUP_ACTIVE;
        end
      end
      PMSUP_DEEP_STBY: begin
        if (wake_hw | wake_tmr) begin
          mode_next = PMSUP_ACTIVE;
        end
      end
      default: mode_next = PMSUP_ACTIVE;
    endcase
    if (thermal_level_two & (mode_reg != PMSUP_THERM_OFF) & (mode_reg != PMSUP_DEEP_STBY)) begin
      mode_next = PMSUP_THERM_OFF;
    end
    if (main_short) begin
      mode_next = PMSUP_DEEP_STBY;
    end
  end

  // ------------------------------------------------------------------
  // Mode and thermal restart bookkeeping
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg        <= PMSUP_ACTIVE;
      toff_cnt_reg    <= '0;
      win_cnt_reg     <= '0;
      restart_cnt_reg <= '0;
    end else begin
      mode_reg     <= mode_next;
      toff_cnt_reg <= (mode_reg == PMSUP_THERM_OFF) ? sat_inc(toff_cnt_reg) : '0;
      if (win_done | (restart_cnt_reg == '0)) begin
        win_cnt_reg <= '0;
      end else begin
        win_cnt_reg <= sat_inc(win_cnt_reg);
      end
      if (mode_reg != PMSUP_THERM_OFF && mode_next == PMSUP_THERM_OFF) begin
        restart_cnt_reg <= win_done ? 3'h1 : restart_cnt_reg + 3'h1;
      end else if (win_done | (mode_next == PMSUP_DEEP_STBY)) begin
        restart_cnt_reg <= '0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Supply filters and short timers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_low_cnt_reg <= '0;
      aux_low_cnt_reg  <= '0;
      main_on_cnt_reg  <= '0;
      aux_on_cnt_reg   <= '0;
      main_up_reg      <= 1'b0;
      aux_up_reg       <= 1'b0;
      wake_in_d_reg    <= '0;
    end else begin
      main_low_cnt_reg <= main_regulator_low ? sat_inc(main_low_cnt_reg) : '0;
      aux_low_cnt_reg  <= aux_regulator_low ? sat_inc(aux_low_cnt_reg) : '0;
      main_on_cnt_reg  <= main_regulator_en ? sat_inc(main_on_cnt_reg) : '0;
      aux_on_cnt_reg   <= aux_regulator_en ? sat_inc(aux_on_cnt_reg) : '0;
      if (main_regulator_en & ~main_regulator_low) begin
        main_up_reg <= 1'b1;
      end
      if (aux_regulator_en & ~aux_regulator_low) begin
        aux_up_reg <= 1'b1;
      end
      wake_in_d_reg <= wake_inputs;
    end
  end

  // ------------------------------------------------------------------
  // Status flags; a set in the clear cycle wins
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_fail_reg     <= 1'b0;
      aux_fail_reg      <= 1'b0;
      aux_short_reg     <= 1'b0;
      forced_reg        <= 1'b0;
      aux_short_off_reg <= 1'b0;
    end else begin
      main_fail_reg <= (main_fail_evt | main_short)
                     | (main_fail_reg & ~(wr_clr & pwdata[CLR_MAIN_FAIL]));
      aux_fail_reg  <= (aux_fail_evt | aux_short)
                     | (aux_fail_reg & ~(wr_clr & pwdata[CLR_AUX_FAIL]));
      aux_short_reg <= aux_short | (aux_short_reg & ~(wr_clr & pwdata[CLR_AUX_SHORT]));
      forced_reg    <= main_short
                     | (toff_done & (mode_reg == PMSUP_THERM_OFF)
                        & (restart_cnt_reg >= RESTART_LIMIT))
                     | (forced_reg & ~(wr_clr & pwdata[CLR_FORCED]));
      aux_short_off_reg <= aux_short | aux_short_off_reg;
    end
  end

  // ------------------------------------------------------------------
  // Control registers and watchdog state
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg                <= CTRL_RESET;
      wake_en_reg             <= WAKE_EN_RESET;
      watchdog_enable_bit_reg <= 1'b1;
      low_cur_reg             <= 1'b0;
      long_win_reg            <= 1'b1;
      tx_flash_d_reg          <= 1'b0;
    end else begin
      tx_flash_d_reg <= in_flash;
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[4:0];
      end
      if (wr_wake) begin
        wake_en_reg <= pwdata[5:0];
      end
      // clear allowed only in CAN flash
      if (wr_wdog & (mode_reg == PMSUP_FLASH_CAN)) begin
        watchdog_enable_bit_reg <= pwdata[0];
      end
      low_cur_reg <= (mode_reg == PMSUP_REG_STBY) & load_current_low;
      // long window after flash exit or wake
      if ((tx_flash_d_reg & ~in_flash) | (mode_reg != PMSUP_ACTIVE && mode_next == PMSUP_ACTIVE)) begin
        long_win_reg <= 1'b1;
      end else if (wr_wdog) begin
        long_win_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Wake indication pulse
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= '0;
    end else if ((mode_reg == PMSUP_REG_STBY) & (mode_next == PMSUP_ACTIVE)) begin
      pulse_cnt_reg <= CNT_W'(WAKE_PULSE_CYC);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  wire standby = (mode_reg == PMSUP_REG_STBY);
  wire hot     = thermal_level_one | (mode_reg == PMSUP_THERM_OFF);
  wire off_all = (mode_reg == PMSUP_DEEP_STBY);
  assign main_regulator_en     = ~(off_all | (mode_reg == PMSUP_THERM_OFF));
  assign aux_regulator_en      = ctrl_reg[CTRL_AUX_ON] & ~hot & ~aux_short_off_reg;
  assign hs_out_en             = ctrl_reg[CTRL_HS_ON] & ~hot;
  assign relay_en              = ctrl_reg[CTRL_REL_ON] & ~hot & ~standby & ~off_all;
  assign lin_tx_en             = ~hot & ~standby & ~off_all;
  assign can_trx_en            = (mode_reg == PMSUP_FLASH_CAN) | (~standby & ~off_all);
  assign main_low_current      = low_cur_reg;
  assign watchdog_run          = watchdog_enable_bit_reg & ~in_flash & ~low_cur_reg
                               & main_regulator_en;
  assign watchdog_long_window  = long_win_reg;
  assign lin_rx_wake_irq_pin_n = (pulse_cnt_reg == '0);
  // no reset pulse on flash exit
  assign mcu_reset_out_n       = main_regulator_en;

  // APB read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        ADDR_CTRL: prdata <= {27'h000_0000, ctrl_reg};
        ADDR_WAKE: prdata <= {26'h000_0000, wake_en_reg};
        ADDR_STAT: prdata <= {22'h00_0000, restart_cnt_reg, 3'(mode_reg),
                              forced_reg, aux_short_reg, aux_fail_reg, main_fail_reg};
        ADDR_WDOG: prdata <= {31'h0000_0000, watchdog_enable_bit_reg};
        default:   prdata <= '0;
      endcase
    end
  end

endmodule : pmsup_top
`default_nettype wire

//--- power_mode_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_mode_supervisor_tb
  import pmsup_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, n0, irq_count, irq_len;
  logic thermal_level_one, thermal_level_two, main_regulator_low, aux_regulator_low;
  logic load_current_low, lin_tx_flash, can_tx_flash, can_wake, lin_wake;
  logic [2:0] wake_inputs;
  logic wake_interrupt_timer, want_can_flash, want_lin_flash, serr;
  logic main_regulator_en, aux_regulator_en, main_low_current, hs_out_en, relay_en;
  logic lin_tx_en, can_trx_en, watchdog_run, watchdog_long_window;
  logic lin_rx_wake_irq_pin_n, mcu_reset_out_n;
  int fail_count, checks_done;
  // Short thermal and short-detect counts keep the run brief
  pmsup_top #(.THERM_OFF_CYCLES(50), .THERM_WIN_CYCLES(2000), .SHORT_DET_CYCLES(100)) DUT (.*);
  pmsup_mcu_model u_mcu (.*);
  always #20 pclk = ~pclk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // This wait ends at the first edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task fire(input int i);
    case (i)
      0: can_wake <= 1'b1;
      1: lin_wake <= 1'b1;
      5: wake_interrupt_timer <= 1'b1;
      default: wake_inputs[i-2] <= ~wake_inputs[i-2];
    endcase
    cyc(4);
    can_wake <= 1'b0; lin_wake <= 1'b0; wake_interrupt_timer <= 1'b0;
  endtask : fire
  // Enter regulated standby, raise one source, expect a wake or none
  task stby_wake(input int i, input logic exp);
    xfer(1'b1, ADDR_CTRL, 32'h0000_001D);
    cyc(2);
    chk("relay", 32'h0, relay_en);
    chk("lin tx", 32'h0, lin_tx_en);
    chk("can trx", 32'h0, can_trx_en);
    chk("hs kept", 32'h1, hs_out_en);
    chk("aux kept", 32'h1, aux_regulator_en);
    load_current_low <= 1'b1;
    cyc(3);
    chk("low current", 32'h1, main_low_current);
    chk("wdog stby", 32'h0, watchdog_run);
    load_current_low <= 1'b0;
    n0 = irq_count;
    fire(i);
    cyc(1500);
    chk("irq count", n0 + 32'(exp), irq_count);
    if (exp) chk("irq len", WAKE_PULSE_CYC, irq_len);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("mode wake", exp ? 32'h0 : 32'h3, 32'(rd[6:4]));
    if (!exp) begin
      fire(0);
      cyc(1500);
    end
  endtask : stby_wake
  task rst;
    presetn <= 1'b0;
    cyc(12);
    presetn <= 1'b1;
  endtask : rst
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {thermal_level_one, thermal_level_two, main_regulator_low, aux_regulator_low} = '0;
    {load_current_low, can_wake, lin_wake, wake_inputs, wake_interrupt_timer} = '0;
    {want_can_flash, want_lin_flash, fail_count, checks_done} = '0;
    rst;
    xfer(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'(CTRL_RESET), 32'(rd[4:0]));
    xfer(1'b0, ADDR_WAKE, 32'h0);
    chk("wake reset", 32'(WAKE_EN_RESET), 32'(rd[5:0]));
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, 32'(serr));
    want_can_flash <= 1'b1;
    cyc(4);
    chk("can trx flash", 32'h1, can_trx_en);
    xfer(1'b1, ADDR_CTRL, 32'h0000_001D);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("mode can flash", 32'h1, 32'(rd[6:4]));
    xfer(1'b1, ADDR_WDOG, 32'h0);
    want_can_flash <= 1'b0;
    cyc(4);
    chk("no reset", 32'h1, mcu_reset_out_n);
    chk("long window", 32'h1, watchdog_long_window);
    xfer(1'b0, ADDR_WDOG, 32'h0);
    chk("wdog bit", 32'h0, 32'(rd[0]));
    chk("debug wdog", 32'h0, watchdog_run);
    rst;
    want_lin_flash <= 1'b1;
    cyc(4);
    xfer(1'b1, ADDR_WDOG, 32'h0);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("mode lin flash", 32'h2, 32'(rd[6:4]));
    xfer(1'b0, ADDR_WDOG, 32'h0);
    chk("wdog locked", 32'h1, 32'(rd[0]));
    want_lin_flash <= 1'b0;
    cyc(4);
    chk("wdog restart", 32'h1, watchdog_run);
    for (int i = 0; i < 5; i++) stby_wake(i, 1'b1);
    stby_wake(5, 1'b0);
    xfer(1'b1, ADDR_WAKE, 32'h0000_003F);
    stby_wake(5, 1'b1);
    thermal_level_one <= 1'b1;
    cyc(3);
    chk("main on tl1", 32'h1, main_regulator_en);
    thermal_level_one <= 1'b0;
    thermal_level_two <= 1'b1;
    cyc(3);
    fire(1);
    cyc(20);
    chk("wake ignored", 32'h0, main_regulator_en);
    cyc(600);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("deep mode", 32'h5, 32'(rd[6:4]));
    chk("forced flag", 32'h1, 32'(rd[3]));
    thermal_level_two <= 1'b0;
    fire(1);
    cyc(10);
    chk("deep wake", 32'h1, main_regulator_en);
    xfer(1'b1, ADDR_CLR, 32'h0000_0008);
    cyc(2100);
    thermal_level_two <= 1'b1;
    cyc(3);
    thermal_level_two <= 1'b0;
    cyc(80);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("one restart", 32'h1, 32'(rd[9:7]));
    chk("forced clr", 32'h0, 32'(rd[3]));
    cyc(2100);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("window clear", 32'h0, 32'(rd[9:7]));
    main_regulator_low <= 1'b1;
    cyc(30);
    main_regulator_low <= 1'b0;
    aux_regulator_low <= 1'b1;
    cyc(60);
    aux_regulator_low <= 1'b0;
    cyc(2);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("short glitch", 32'h0, 32'(rd[0]));
    chk("aux fail", 32'h1, 32'(rd[1]));
    xfer(1'b1, ADDR_CLR, 32'h0000_0002);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("aux fail clr", 32'h0, 32'(rd[1]));
    // Both regulators held low from power-up: shorts on each
    {main_regulator_low, aux_regulator_low} <= 2'b11;
    rst;
    cyc(130);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("short flags", 32'h5F, 32'(rd[6:0]));
    chk("aux short off", 32'h0, aux_regulator_en);
    chk("main short off", 32'h0, main_regulator_en);
    give_verdict;
  end
  // Hang guard, about twice the expected run
  initial begin
    cyc(40000);
    fail_count++;
    give_verdict;
  end
endmodule : power_mode_supervisor_tb
`default_nettype wire
